// >>> sad_converter.sv
`timescale 1ns/10ps
// What this block does
// - Frame select falling starts conversion and transfer, enabling the data output.
// - Analog input is sampled on frame select fall; track switches to hold.
// - Serial clock edges are counted from frame select fall, first edge is one.
// - Hold phase steps the DAC code bit by bit through all eight bits, one per rising edge.
// - Hold returns to track on the thirteenth rising serial clock edge.
// - Data output released after sixteenth falling edge or frame select rise.
// - Sixteen cycles per sample; bits change on falling, captured on rising.
// - Word is three zeros, eight result bits MSB first, four zeros.
// - Host allows for an extra leading zero if select falls before rising edge.
// - Result is straight binary, step is supply over 256.
// - Frame select low enters normal mode and starts a conversion.
// - Rise from second up to before tenth falling edge enters shutdown, else stays normal.
// - Shutdown holds until frame select is next driven low.
// - Shutdown only for rises between second and tenth falling edges.
// - Rise between tenth and sixteenth falling edges aborts word, stays normal.
module sad_converter
    import sad_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    // Serial link, sampled on ref_clk
    input  wire logic                  frameSelect_n,
    input  wire logic                  serialClk,
    output logic                       serial_result_out,
    output logic                       serialOutEn,
    // Analog front end
    input  wire logic                  compGreater,
    output logic [sad_pkg::RESULT_W-1:0] dacCode,
    output logic                       trackHold,
    output logic                       shutdown,
    // Completed results
    output logic [sad_pkg::RESULT_W-1:0] resultData,
    output logic                       resultValid,
    input  wire logic                  resultReady,
    output logic                       resultDropped
);
    import sad_pkg::*;

    // ------------------------------------------------------------
    // Edge detection on the link pins
    // ------------------------------------------------------------
    logic             selPrev;
    logic             sclkPrev;
    logic             selFall;
    logic             selRise;
    logic             sclkRise;
    logic             sclkFall;

    always_comb begin
        selFall  = selPrev && !frameSelect_n;
        selRise  = !selPrev && frameSelect_n;
        sclkRise = !sclkPrev && serialClk;
        sclkFall = sclkPrev && !serialClk;
    end

    // ------------------------------------------------------------
    // Frame state and edge counters
    // ------------------------------------------------------------
    sad_state_t       state;
    sad_state_t       next_state;
    logic [EDGE_W-1:0] riseCnt;
    logic [EDGE_W-1:0] fallCnt;
    logic [EDGE_W-1:0] next_riseCnt;
    logic [EDGE_W-1:0] next_fallCnt;
    logic [RESULT_W-1:0] sar;
    logic [RESULT_W-1:0] trial;
    logic [RESULT_W-1:0] next_sar;
    logic [RESULT_W-1:0] next_trial;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] next_result;
    logic             next_trackHold;
    logic             next_shutdown;
    logic             outBit;
    logic             next_outBit;
    logic             next_outEn;
    logic             pushValid;
    logic             next_pushValid;
    logic             pushReady;

    // Bit shown after falling edge n: zeros, result MSB first, zeros
    function automatic logic wordBit(input logic [EDGE_W-1:0] n,
                                     input logic [RESULT_W-1:0] r);
        logic [EDGE_W-1:0] idx;
        idx = n - LEAD_ZEROS - 1'b1;
        if (n <= LEAD_ZEROS || idx >= EDGE_W'(RESULT_W)) begin
            return 1'b0;
        end
        return r[3'(RESULT_W - 1 - int'(idx))];
    endfunction

    always_comb begin
        next_state     = state;
        next_riseCnt   = riseCnt;
        next_fallCnt   = fallCnt;
        next_sar       = sar;
        next_trial     = trial;
        next_result    = result;
        next_trackHold = trackHold;
        next_shutdown  = shutdown;
        next_outBit    = outBit;
        next_outEn     = serialOutEn;
        // One-cycle push; a full queue drops the word rather than holding it
        next_pushValid = 1'b0;
        unique case (state)
            SAD_IDLE: begin
                if (selFall) begin
                    next_state     = SAD_CONV;
                    next_riseCnt   = '0;
                    next_fallCnt   = '0;
                    next_trackHold = 1'b1;
                    next_shutdown  = 1'b0;
                    next_outEn     = 1'b1;
                    next_outBit    = 1'b0;
                    next_sar       = RESULT_RESET;
                    next_trial     = SAR_TOP_BIT;
                end
            end
            SAD_CONV: begin
                if (selRise) begin
                    // Early rise aborts; mode depends on how far the frame got
                    next_state     = SAD_IDLE;
                    next_outEn     = 1'b0;
                    next_trackHold = 1'b0;
                    if (fallCnt >= EDGE_SHDN_MIN && fallCnt < EDGE_SHDN_MAX) begin
                        next_shutdown = 1'b1;
                    end
                end else begin
                    if (sclkRise) begin
                        next_riseCnt = riseCnt + 1'b1;
                        // One SAR decision per rising edge while bits remain
                        if (trackHold && trial != '0) begin
                            if (compGreater) begin
                                next_sar = sar | trial;
                            end
                            next_trial = trial >> 1;
                            if (trial == 8'h01) begin
                                next_result = compGreater ? (sar | trial) : sar;
                            end
                        end
                        if (riseCnt + 1'b1 == EDGE_HOLD_END) begin
                            next_trackHold = 1'b0;
                        end
                    end
                    if (sclkFall) begin
                        next_fallCnt = fallCnt + 1'b1;
                        // Live SAR bits: the final result lands after its first bit is due
                        next_outBit  = wordBit(fallCnt + 1'b1, sar);
                        if (fallCnt + 1'b1 == EDGE_LAST) begin
                            next_state     = SAD_DONE;
                            next_outEn     = 1'b0;
                            next_pushValid = 1'b1;
                        end
                    end
                end
            end
            SAD_DONE: begin
                // Extra clocks are ignored until select returns high
                if (selRise) begin
                    next_state = SAD_IDLE;
                end
            end
            default: begin
                next_state = SAD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state       <= SAD_IDLE;
            selPrev     <= 1'b1;
            sclkPrev    <= 1'b0;
            riseCnt     <= '0;
            fallCnt     <= '0;
            sar         <= RESULT_RESET;
            trial       <= '0;
            result      <= RESULT_RESET;
            trackHold   <= 1'b0;
            shutdown    <= 1'b0;
            outBit      <= 1'b0;
            serialOutEn <= 1'b0;
            pushValid   <= 1'b0;
        end else begin
            state       <= next_state;
            selPrev     <= frameSelect_n;
            sclkPrev    <= serialClk;
            riseCnt     <= next_riseCnt;
            fallCnt     <= next_fallCnt;
            sar         <= next_sar;
            trial       <= next_trial;
            result      <= next_result;
            trackHold   <= next_trackHold;
            shutdown    <= next_shutdown;
            outBit      <= next_outBit;
            serialOutEn <= next_outEn;
            pushValid   <= next_pushValid;
        end
    end

    assign serial_result_out = outBit;
    assign dacCode           = sar | trial;
    // A full queue cannot stall the link, so an overrun is flagged instead
    assign resultDropped     = pushValid && !pushReady;

    // ------------------------------------------------------------
    // Result queue
    // ------------------------------------------------------------
    sad_fifo #(
        .WIDTH (RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) resultQueue (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .inData   (result),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .outData  (resultData),
        .outValid (resultValid),
        .outReady (resultReady)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_fall_enables: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state == SAD_IDLE && selFall |=> serialOutEn && trackHold)
        else $error("Output not enabled after select fall");

    a_rise_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state == SAD_CONV && selRise |=> !serialOutEn)
        else $error("Output not released on select rise");

    a_last_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state == SAD_CONV && !selRise && sclkFall && fallCnt == 5'h0f |=> !serialOutEn)
        else $error("Output not released after sixteenth fall");

    a_track_at_13: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state == SAD_CONV && !selRise && sclkRise && riseCnt == 5'h0c |=> !trackHold)
        else $error("No return to track on thirteenth rise");

    a_lead_zeros: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state == SAD_CONV && serialOutEn && fallCnt <= LEAD_ZEROS |-> !serial_result_out)
        else $error("Leading bit not zero");

    a_shdn_window: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state == SAD_CONV && selRise && fallCnt < EDGE_SHDN_MIN |=> shutdown == $past(shutdown))
        else $error("Mode changed by early select rise");

    a_shdn_enter: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state == SAD_CONV && selRise && fallCnt >= EDGE_SHDN_MIN
        && fallCnt < EDGE_SHDN_MAX |=> shutdown)
        else $error("Shutdown not entered");

    a_wake_on_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state == SAD_IDLE && selFall |=> !shutdown)
        else $error("Select fall did not wake");

    a_shdn_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state == SAD_IDLE && !selFall |=> shutdown == $past(shutdown))
        else $error("Mode changed while idle");

    sequence s_doneHeld;
        state == SAD_DONE && !selRise;
    endsequence

    a_done_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_doneHeld |=> !serialOutEn && $stable(fallCnt))
        else $error("Activity after word end");
endmodule

// >>> sad_pkg.sv
package sad_pkg;
    // ------------------------------------------------------------
    // Widths and frame layout
    // ------------------------------------------------------------
    localparam int          RESULT_W       = 8;
    localparam int          WORD_W         = 16;
    localparam int          EDGE_W         = 5;
    localparam int          FIFO_DEPTH     = 8;
    localparam logic [4:0]  LEAD_ZEROS     = 5'h03;
    localparam logic [4:0]  EDGE_HOLD_END  = 5'h0d;
    localparam logic [4:0]  EDGE_SHDN_MIN  = 5'h02;
    localparam logic [4:0]  EDGE_SHDN_MAX  = 5'h0a;
    localparam logic [4:0]  EDGE_LAST      = 5'h10;
    localparam logic [7:0]  RESULT_RESET   = 8'h00;
    localparam logic [7:0]  SAR_TOP_BIT    = 8'h80;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_PS  = 4000;
    localparam int          ACQ_TIME_NS    = 350;
    localparam int          ACQ_CYCLES     = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // Frame states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SAD_IDLE   = 2'b00,
        SAD_CONV   = 2'b01,
        SAD_DONE   = 2'b11
    } sad_state_t;
endpackage

// >>> sad_fifo.sv
`timescale 1ns/10ps
module sad_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Drain side
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;
    logic [AW:0]      next_wrPtr;
    logic [AW:0]      next_rdPtr;
    logic             doWr;
    logic             doRd;

    assign inReady  = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
    assign outValid = wrPtr != rdPtr;
    assign outData  = mem[rdPtr[AW-1:0]];

    always_comb begin
        doWr       = inValid && inReady;
        doRd       = outValid && outReady;
        next_wrPtr = doWr ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = doRd ? rdPtr + 1'b1 : rdPtr;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
        end
    end

    // Storage has no reset; only the pointers must be defined
    always_ff @(posedge ref_clk) begin
        if (doWr) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end
endmodule

// >>> sad_host_model.sv
`timescale 1ns/10ps
module sad_host_model (
    // Clock
    input  wire logic                         ref_clk,
    // Serial link
    output logic                              frameSelect_n,
    output logic                              serialClk,
    input  wire logic                         serial_result_out,
    input  wire logic                         serialOutEn,
    // Analog side
    input  wire logic [sad_pkg::RESULT_W-1:0] dacCode,
    input  wire logic                         trackHold,
    output logic                              compGreater
);
    import sad_pkg::*;
    localparam int QUIET = 16;
    logic [RESULT_W-1:0] level = 8'h00;
    logic                lastBit = 1'b0;
    logic                pin;
    // ------------------------------------------------------------
    // Comparator and data pin
    // ------------------------------------------------------------
    assign compGreater = (dacCode <= level);
    // A released pin toggles each cycle, so a stale bit never passes
    assign pin = serialOutEn ? serial_result_out : ~lastBit;
    always @(posedge ref_clk) lastBit <= pin;
    initial begin
        frameSelect_n = 1'b1;
        serialClk     = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge ref_clk);
    endtask
    // ------------------------------------------------------------
    // One frame; clock stands low outside frames
    // ------------------------------------------------------------
    task automatic frame(input logic [7:0] lvl, input int falls, input int extra,
                         output logic [15:0] word, output logic [3:0] flags);
        word  = 16'h0000;
        flags = 4'b1100;
        @(posedge ref_clk);
        level         <= lvl;
        frameSelect_n <= 1'b0;
        for (int n = 1; n <= falls + extra; n++) begin
            half();
            if (n <= 16) begin
                word[16-n] = pin;
                flags[3]   = flags[3] & serialOutEn;
            end
            if (n == 13) flags[1] = trackHold;
            serialClk <= 1'b1;
            if (n == 13) repeat (ACQ_CYCLES) @(posedge ref_clk);
            else half();
            serialClk <= 1'b0;
        end
        half();
        flags[2]      = serialOutEn;
        flags[0]      = trackHold;
        frameSelect_n <= 1'b1;
        repeat (QUIET) @(posedge ref_clk);
    endtask
endmodule

// >>> sar_adc_serial_frame_and_power_mode_test.sv
`timescale 1ns/10ps
module sar_adc_serial_frame_and_power_mode_test;
    import sad_pkg::*;
    // ------------------------------------------------------------
    // Clock, reset and wiring
    // ------------------------------------------------------------
    logic                ref_clk;
    logic                reset_n;
    logic                frameSelect_n;
    logic                serialClk;
    logic                serial_result_out;
    logic                serialOutEn;
    logic                compGreater;
    logic [RESULT_W-1:0] dacCode;
    logic                trackHold;
    logic                shutdown;
    logic [RESULT_W-1:0] resultData;
    logic                resultValid;
    logic                resultReady;
    logic                resultDropped;
    logic [15:0]         word;
    logic [3:0]          flags;
    int                  num_errors = 0;
    int                  n_checks   = 0;
    int                  dropCnt    = 0;
    logic [7:0]          vals [9]   = '{8'h00, 8'hff, 8'ha5, 8'h5a, 8'h01,
                                        8'h80, 8'h7f, 8'hfe, 8'h3c};
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    sad_converter u_sad_converter (
        .ref_clk(ref_clk), .reset_n(reset_n), .frameSelect_n(frameSelect_n),
        .serialClk(serialClk), .serial_result_out(serial_result_out),
        .serialOutEn(serialOutEn), .compGreater(compGreater), .dacCode(dacCode),
        .trackHold(trackHold), .shutdown(shutdown), .resultData(resultData),
        .resultValid(resultValid), .resultReady(resultReady),
        .resultDropped(resultDropped));
    sad_host_model u_sad_host_model (
        .ref_clk(ref_clk), .frameSelect_n(frameSelect_n), .serialClk(serialClk),
        .serial_result_out(serial_result_out), .serialOutEn(serialOutEn),
        .dacCode(dacCode), .trackHold(trackHold), .compGreater(compGreater));
    always @(posedge ref_clk) if (resultDropped === 1'b1) dropCnt++;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [7:0] v, input int falls, input int extra);
        u_sad_host_model.frame(v, falls, extra, word, flags);
    endtask
    task automatic pop_check(input logic [7:0] v);
        check({7'h00, resultValid, resultData}, {8'h01, v});
        @(posedge ref_clk);
        resultReady <= 1'b1;
        @(posedge ref_clk);
        resultReady <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check({12'h000, serialOutEn, trackHold, shutdown, resultValid}, 16'h0000);
        $display("t_reset done");
    endtask
    // Nine full frames with no drain: the ninth result overruns
    task automatic t_frames();
        foreach (vals[i]) begin
            run(vals[i], 16, 0);
            check(word, {4'h0, vals[i], 4'h0});
            check({12'h000, flags}, 16'h000a);
        end
        check(16'(dropCnt), 16'h0001);
        for (int i = 0; i < FIFO_DEPTH; i++) pop_check(vals[i]);
        check({15'h0000, resultValid}, 16'h0000);
        $display("t_frames done");
    endtask
    task automatic t_modes();
        int         k [5] = '{1, 2, 9, 10, 5};
        logic [4:0] sd    = 5'b10110;
        for (int i = 0; i < 5; i++) begin
            run(8'h44, k[i], 0);
            check({11'h000, shutdown, flags[3:2], serialOutEn, resultValid},
                  {11'h000, sd[i], 4'b1100});
        end
        repeat (40) @(posedge ref_clk);
        check({15'h0000, shutdown}, 16'h0001);
        // The wake-up result is thrown away as it lands
        resultReady <= 1'b1;
        run(8'h33, 16, 0);
        resultReady <= 1'b0;
        check({15'h0000, shutdown}, 16'h0000);
        run(8'hc6, 16, 0);
        check(word, {4'h0, 8'hc6, 4'h0});
        pop_check(8'hc6);
        $display("t_modes done");
    endtask
    task automatic t_extra();
        run(8'h96, 16, 3);
        check(word, {4'h0, 8'h96, 4'h0});
        check({12'h000, flags}, 16'h000a);
        pop_check(8'h96);
        check({15'h0000, resultValid}, 16'h0000);
        $display("t_extra done");
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        reset_n     = 1'b0;
        resultReady = 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_frames();
        t_modes();
        t_extra();
        finish_test();
    end
    // About twenty frames of some 250 cycles each; twelve times that is a hang
    initial begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        finish_test();
    end
endmodule
